// [rtl/sppr_router.sv]
// Serial port pin router: swap and selection registers, pin and interrupt steering
//
// Contract
// - Channel two swap selects P94/P93 receive/transmit
// - Channel one swap selects P91/P90 receive/transmit
// - Channel zero group picks P20/P21 or PB4/PB5
// - Swap register bits three to seven read zero
// - Select 00 routes UART zero plus I2C
// - Select 01 UART+SIO; 10 SIO+I2C with group bit clear; others reserved
// - Second select: UART on P90/P91, or SIO
// - Swap bits reset zero; upper bits read-only
`timescale 1ns/1ps
module sppr_router #(
  parameter int ADDR_W = 12
) (
  input  wire logic                          clk_i,
  input  wire logic                          srst_i,
  input  wire logic                          ce_i,
  input  wire logic [ADDR_W-1:0]             addr_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  input  wire logic [7:0]                    wdata_i,
  output logic      [7:0]                    rdata_o,
  input  wire logic [sppr_pkg::NUM_PINS-1:0] pin_in_i,
  output logic      [sppr_pkg::NUM_PINS-1:0] pin_out_o,
  output logic      [sppr_pkg::NUM_PINS-1:0] pin_oe_o,
  output logic      [sppr_pkg::NUM_PINS-1:0] pin_claim_o,
  input  wire logic                          uart0_txd_i,
  input  wire logic                          uart1_txd_i,
  input  wire logic                          uart2_txd_i,
  output logic                               uart0_rxd_o,
  output logic                               uart1_rxd_o,
  output logic                               uart2_rxd_o,
  input  wire logic                          clocked_serial_out_first_i,
  input  wire logic                          clocked_serial_clk_first_i,
  input  wire logic                          clocked_serial_clk_oe_first_i,
  output logic                               clocked_serial_in_first_o,
  output logic                               clocked_serial_clk_first_o,
  input  wire logic                          clocked_serial_out_second_i,
  input  wire logic                          clocked_serial_clk_second_i,
  input  wire logic                          clocked_serial_clk_oe_second_i,
  output logic                               clocked_serial_in_second_o,
  output logic                               clocked_serial_clk_second_o,
  input  wire logic                          i2c_sda_low_i,
  input  wire logic                          i2c_scl_low_i,
  output logic                               i2c_sda_o,
  output logic                               i2c_scl_o,
  input  wire logic                          tx_irq_chan0_i,
  input  wire logic                          rx_irq_chan0_i,
  input  wire logic                          i2c_irq_i,
  input  wire logic                          clocked_serial_irq_first_i,
  input  wire logic                          clocked_serial_irq_second_i,
  input  wire logic                          tx_irq_chan1_i,
  input  wire logic                          rx_irq_chan1_i,
  output logic                               irq_latch_seven_o,
  output logic                               irq_latch_six_o,
  output logic                               irq_latch_fifteen_o,
  output logic                               irq_latch_twentythree_o,
  output logic                               irq_latch_twentytwo_o
);
  import sppr_pkg::*;

  localparam int IN_W  = 9;
  localparam int IRQ_W = 5;
  localparam int ST_W  = 3 * NUM_PINS + IN_W + IRQ_W;

  initial
  begin
    if (ADDR_W < 12)
    begin
      $error("sppr_router: ADDR_W must be at least 12");
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [2:0]  uart_pin_swap_control;
  logic [4:0]  sel;
  logic [2:0]  next_swap;
  logic [4:0]  next_sel;
  logic [7:0]  next_rdata;
  logic [11:0] addr;

  assign addr = addr_i[11:0];

  always_comb
  begin
    next_swap  = uart_pin_swap_control;
    next_sel   = sel;
    next_rdata = rdata_o;
    if (srst_i)
    begin
      next_swap  = SWAP_RST;
      next_sel   = SEL_RST;
      next_rdata = 8'h00;
    end
    else if (ce_i)
    begin
      if (wr_i && addr == ADDR_SWAP)
      begin
        next_swap = wdata_i[2:0];
      end
      if (wr_i && addr == ADDR_SEL)
      begin
        next_sel = wdata_i[4:0];
      end
      if (rd_i)
      begin
        case (addr)
          ADDR_SWAP: next_rdata = {5'h00, uart_pin_swap_control};
          ADDR_SEL:  next_rdata = {3'h0, sel};
          default:   next_rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    uart_pin_swap_control <= next_swap;
    sel                   <= next_sel;
    rdata_o               <= next_rdata;
  end

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  logic [1:0]  first_pair_select;
  logic [1:0]  second_pair_select;
  logic        chan0_pin_group_select;
  sppr_mode0_t mode0;
  sppr_mode1_t mode1;

  assign first_pair_select      = sel[SEL0_LSB +: 2];
  assign second_pair_select     = sel[SEL1_LSB +: 2];
  assign chan0_pin_group_select = sel[GRP_BIT];

  always_comb
  begin
    case (first_pair_select)
      SEL_UART_I2C: mode0 = M0_UART_I2C;
      SEL_UART_SIO: mode0 = M0_UART_SIO;
      SEL_SIO_I2C:  mode0 = chan0_pin_group_select ? M0_OFF : M0_SIO_I2C;
      default:      mode0 = M0_OFF;
    endcase
    case (second_pair_select)
      SEL_UART_I2C, SEL_UART_SIO: mode1 = M1_UART;
      SEL_SIO_I2C:  mode1 = M1_SIO;
      default:      mode1 = M1_OFF;
    endcase
  end

  // ----------------------------------------------------------------------
  // Pin and interrupt steering
  // ----------------------------------------------------------------------
  logic [NUM_PINS-1:0] n_out;
  logic [NUM_PINS-1:0] n_oe;
  logic [NUM_PINS-1:0] n_claim;
  logic [IN_W-1:0]     n_in;
  logic [IRQ_W-1:0]    n_irq;
  logic                sw0;
  logic                sw1;
  logic                sw2;
  logic                grp;

  assign sw0 = uart_pin_swap_control[SWAP_CH0];
  assign sw1 = uart_pin_swap_control[SWAP_CH1];
  assign sw2 = uart_pin_swap_control[SWAP_CH2];
  assign grp = chan0_pin_group_select;

  // n_in: rxd0 rxd1 rxd2 si0 clocked_serial_clk_first si1 sclk1 sda scl (bit 0 upward)
  // n_irq: seven six fifteen twentythree twentytwo (bit 0 upward)
  always_comb
  begin
    n_out   = '0;
    n_oe    = '0;
    n_claim = '0;
    n_in    = '0;
    n_irq   = '0;
    // Third channel is always on P93/P94
    n_out[sw2 ? PIN_94 : PIN_93] = uart2_txd_i;
    n_oe[sw2 ? PIN_94 : PIN_93]  = 1'b1;
    n_claim[PIN_93]              = 1'b1;
    n_claim[PIN_94]              = 1'b1;
    n_in[2]                      = pin_in_i[sw2 ? PIN_93 : PIN_94];
    // First channel on one of two pin groups
    if (mode0 == M0_UART_I2C || mode0 == M0_UART_SIO)
    begin
      if (grp)
      begin
        n_out[sw0 ? PIN_B5 : PIN_B4] = uart0_txd_i;
        n_oe[sw0 ? PIN_B5 : PIN_B4]  = 1'b1;
        n_in[0]                      = pin_in_i[sw0 ? PIN_B4 : PIN_B5];
        n_claim[PIN_B4]              = 1'b1;
        n_claim[PIN_B5]              = 1'b1;
      end
      else
      begin
        n_out[sw0 ? PIN_21 : PIN_20] = uart0_txd_i;
        n_oe[sw0 ? PIN_21 : PIN_20]  = 1'b1;
        n_in[0]                      = pin_in_i[sw0 ? PIN_20 : PIN_21];
        n_claim[PIN_20]              = 1'b1;
        n_claim[PIN_21]              = 1'b1;
      end
      n_irq[0] = tx_irq_chan0_i;
      n_irq[1] = rx_irq_chan0_i;
    end
    // I2C open drain on P23/P24
    if (mode0 == M0_UART_I2C || mode0 == M0_SIO_I2C)
    begin
      n_oe[PIN_23]    = i2c_sda_low_i;
      n_oe[PIN_24]    = i2c_scl_low_i;
      n_claim[PIN_23] = 1'b1;
      n_claim[PIN_24] = 1'b1;
      n_in[7]         = pin_in_i[PIN_23];
      n_in[8]         = pin_in_i[PIN_24];
      n_irq[2]        = i2c_irq_i;
    end
    // First clocked serial channel
    if (mode0 == M0_UART_SIO)
    begin
      n_out[PIN_23]   = clocked_serial_out_first_i;
      n_oe[PIN_23]    = 1'b1;
      n_out[PIN_25]   = clocked_serial_clk_first_i;
      n_oe[PIN_25]    = clocked_serial_clk_oe_first_i;
      n_in[3]         = pin_in_i[PIN_24];
      n_in[4]         = pin_in_i[PIN_25];
      n_claim[PIN_23] = 1'b1;
      n_claim[PIN_24] = 1'b1;
      n_claim[PIN_25] = 1'b1;
      n_irq[1]        = rx_irq_chan0_i | clocked_serial_irq_first_i;
    end
    if (mode0 == M0_SIO_I2C)
    begin
      n_out[PIN_20]   = clocked_serial_out_first_i;
      n_oe[PIN_20]    = 1'b1;
      n_out[PIN_22]   = clocked_serial_clk_first_i;
      n_oe[PIN_22]    = clocked_serial_clk_oe_first_i;
      n_in[3]         = pin_in_i[PIN_21];
      n_in[4]         = pin_in_i[PIN_22];
      n_claim[PIN_20] = 1'b1;
      n_claim[PIN_21] = 1'b1;
      n_claim[PIN_22] = 1'b1;
      n_irq[1]        = clocked_serial_irq_first_i;
    end
    // Second group on P90..P92
    if (mode1 == M1_UART)
    begin
      n_out[sw1 ? PIN_91 : PIN_90] = uart1_txd_i;
      n_oe[sw1 ? PIN_91 : PIN_90]  = 1'b1;
      n_in[1]                      = pin_in_i[sw1 ? PIN_90 : PIN_91];
      n_claim[PIN_90]              = 1'b1;
      n_claim[PIN_91]              = 1'b1;
      n_irq[3]                     = tx_irq_chan1_i;
      n_irq[4]                     = rx_irq_chan1_i;
    end
    else if (mode1 == M1_SIO)
    begin
      n_out[PIN_90]   = clocked_serial_out_second_i;
      n_oe[PIN_90]    = 1'b1;
      n_out[PIN_92]   = clocked_serial_clk_second_i;
      n_oe[PIN_92]    = clocked_serial_clk_oe_second_i;
      n_in[5]         = pin_in_i[PIN_91];
      n_in[6]         = pin_in_i[PIN_92];
      n_claim[PIN_90] = 1'b1;
      n_claim[PIN_91] = 1'b1;
      n_claim[PIN_92] = 1'b1;
      n_irq[4]        = clocked_serial_irq_second_i;
    end
  end

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  logic [ST_W-1:0] st_q;

  sppr_stage #(.WIDTH(ST_W)) u_stage (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .ce_i   (ce_i),
    .d_i    ({n_irq, n_in, n_claim, n_oe, n_out}),
    .q_o    (st_q)
  );

  assign {irq_latch_twentytwo_o, irq_latch_twentythree_o, irq_latch_fifteen_o,
          irq_latch_six_o, irq_latch_seven_o,
          i2c_scl_o, i2c_sda_o, clocked_serial_clk_second_o, clocked_serial_in_second_o,
          clocked_serial_clk_first_o, clocked_serial_in_first_o,
          uart2_rxd_o, uart1_rxd_o, uart0_rxd_o,
          pin_claim_o, pin_oe_o, pin_out_o} = st_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_chan2_normal: assert property (ce_i && !sw2 |=> pin_out_o[PIN_93] == $past(uart2_txd_i)
    && pin_oe_o[PIN_93] && !pin_oe_o[PIN_94] && uart2_rxd_o == $past(pin_in_i[PIN_94]))
    else $error("channel two pins misrouted");
  a_chan1_swapped: assert property (ce_i && sw1 && mode1 == M1_UART
    |=> pin_out_o[PIN_91] == $past(uart1_txd_i) && uart1_rxd_o == $past(pin_in_i[PIN_90]))
    else $error("channel one swap misrouted");
  a_chan0_group: assert property (ce_i && grp && !sw0 && mode0 == M0_UART_I2C
    |=> pin_out_o[PIN_B4] == $past(uart0_txd_i) && uart0_rxd_o == $past(pin_in_i[PIN_B5])
    && !pin_claim_o[PIN_20])
    else $error("channel zero group misrouted");
  a_swap_readback: assert property (ce_i && rd_i && addr == ADDR_SWAP
    |=> rdata_o[7:3] == 5'h00 && rdata_o[2:0] == $past(uart_pin_swap_control))
    else $error("swap register readback wrong");
  a_i2c_latches: assert property (ce_i && mode0 == M0_UART_I2C
    |=> irq_latch_fifteen_o == $past(i2c_irq_i) && irq_latch_seven_o == $past(tx_irq_chan0_i)
    && pin_oe_o[PIN_23] == $past(i2c_sda_low_i) && !pin_out_o[PIN_23])
    else $error("i2c routing wrong");
  a_clocked_serial_first_share: assert property (ce_i && mode0 == M0_UART_SIO
    |=> irq_latch_six_o == $past(rx_irq_chan0_i || clocked_serial_irq_first_i)
    && pin_out_o[PIN_25] == $past(clocked_serial_clk_first_i))
    else $error("first clocked serial routing wrong");
  a_clocked_serial_second_route: assert property (ce_i && mode1 == M1_SIO
    |=> pin_out_o[PIN_90] == $past(clocked_serial_out_second_i)
    && irq_latch_twentytwo_o == $past(clocked_serial_irq_second_i) && !irq_latch_twentythree_o)
    else $error("second clocked serial routing wrong");
  a_reset_zero: assert property ($fell(srst_i) |-> uart_pin_swap_control == 3'h0
    && sel == 5'h00 && pin_oe_o == '0)
    else $error("registers not zero after reset");
  a_reserved_idle: assert property (ce_i && mode0 == M0_OFF ##1 ce_i && mode0 == M0_OFF
    |=> pin_claim_o[PIN_25:PIN_B4] == 8'h00 && !irq_latch_six_o && !irq_latch_fifteen_o)
    else $error("reserved selection drives pins");

  c_uart_i2c: cover property (ce_i && mode0 == M0_UART_I2C && grp);
  c_sio_i2c:  cover property (ce_i && mode0 == M0_SIO_I2C);
  c_clocked_serial_second:     cover property (ce_i && mode1 == M1_SIO && sw2);
  c_reserved: cover property (ce_i && mode1 == M1_OFF && mode0 == M0_OFF);

endmodule : sppr_router

// [rtl/sppr_pkg.sv]
// Package: register map, pin indices and selection encodings of the serial pin router
package sppr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_SWAP = 12'hF57;
  localparam logic [11:0] ADDR_SEL  = 12'hFCB;

  localparam logic [2:0] SWAP_RST = 3'h0;
  localparam logic [4:0] SEL_RST  = 5'h0;

  localparam int SWAP_CH0 = 0;
  localparam int SWAP_CH1 = 1;
  localparam int SWAP_CH2 = 2;
  localparam int SEL0_LSB = 0;
  localparam int SEL1_LSB = 2;
  localparam int GRP_BIT  = 4;

  localparam logic [1:0] SEL_UART_I2C = 2'h0;
  localparam logic [1:0] SEL_UART_SIO = 2'h1;
  localparam logic [1:0] SEL_SIO_I2C  = 2'h2;
  localparam logic [1:0] SEL_RSV      = 2'h3;

  // ----------------------------------------------------------------------
  // Pin indices on the pin vectors
  // ----------------------------------------------------------------------
  localparam int PIN_B4   = 0;
  localparam int PIN_B5   = 1;
  localparam int PIN_20   = 2;
  localparam int PIN_21   = 3;
  localparam int PIN_22   = 4;
  localparam int PIN_23   = 5;
  localparam int PIN_24   = 6;
  localparam int PIN_25   = 7;
  localparam int PIN_90   = 8;
  localparam int PIN_91   = 9;
  localparam int PIN_92   = 10;
  localparam int PIN_93   = 11;
  localparam int PIN_94   = 12;
  localparam int NUM_PINS = 13;

  // Routing of the first shared pin group
  typedef enum logic [1:0] {
    M0_UART_I2C,
    M0_UART_SIO,
    M0_SIO_I2C,
    M0_OFF
  } sppr_mode0_t;

  // Routing of the second shared pin group
  typedef enum logic [1:0] {
    M1_UART,
    M1_SIO,
    M1_OFF
  } sppr_mode1_t;

endpackage : sppr_pkg

// [rtl/sppr_stage.sv]
// Output register bank with clock enable and synchronous reset
`timescale 1ns/1ps
module sppr_stage #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] next_q;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("sppr_stage: WIDTH must be at least 1");
    end
  end

  always_comb
  begin
    next_q = q_o;
    if (srst_i)
    begin
      next_q = '0;
    end
    else if (ce_i)
    begin
      next_q = d_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    q_o <= next_q;
  end

endmodule : sppr_stage

// [tb/sppr_far_model.sv]
// Far-side model: serial engine transmit levels and external pin levels
`timescale 1ns/1ps
module sppr_far_model (
  input  wire logic        run_i,
  input  wire logic [2:0]  tx_pat_i,
  input  wire logic [12:0] pin_pat_i,
  input  wire logic [12:0] claim_i,
  output logic      [2:0]  txd_o,
  output logic      [12:0] pin_o
);
  // Stopped engines idle high, so a swap change never cuts a frame
  assign txd_o = run_i ? tx_pat_i : 3'h7;
  // Unclaimed pins belong to port logic and carry unrelated levels
  assign pin_o = (pin_pat_i & claim_i) | (~pin_pat_i & ~claim_i);
endmodule : sppr_far_model

// [tb/serial_port_pin_router_tb_top.sv]
// Testbench of the serial port pin router
`timescale 1ns/1ps
module serial_port_pin_router_tb_top;
  import sppr_pkg::*;

  typedef struct packed {
    logic [7:0]  sel;
    logic [7:0]  swap;
    logic [12:0] claim;
    logic [23:0] pins;
    logic [6:0]  irq;
    logic [4:0]  lat;
  } sppr_row_t;

  // --------------------------------------------------------------------
  // Rows: select, swap, claimed pins, tx/rx pin per channel, irq in/out
  // --------------------------------------------------------------------
  sppr_row_t rows [8] = '{
    {8'h00, 8'h00, 13'h1B6C, 24'h2389BC, 7'h40, 5'h10},
    {8'h00, 8'h07, 13'h1B6C, 24'h3298CB, 7'h21, 5'h09},
    {8'h10, 8'h00, 13'h1B63, 24'h0189BC, 7'h12, 5'h06},
    {8'h11, 8'h01, 13'h1BE3, 24'h1089BC, 7'h18, 5'h08},
    {8'h05, 8'h00, 13'h1BEC, 24'h2389BC, 7'h52, 5'h12},
    {8'h0A, 8'h00, 13'h1F7C, 24'hFFFFBC, 7'h6F, 5'h09},
    {8'h1E, 8'h00, 13'h1800, 24'hFFFFBC, 7'h7F, 5'h00},
    {8'h0F, 8'h04, 13'h1800, 24'hFFFFCB, 7'h7F, 5'h00}
  };

  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic [11:0] addr = 12'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        run = 1'b0;
  logic        v = 1'b0;
  logic [7:0]  wdata = 8'h0;
  logic [7:0]  rdata;
  logic [12:0] pin_pat = 13'h0;
  logic [12:0] pin_in;
  logic [12:0] pin_out;
  logic [12:0] pin_oe;
  logic [12:0] claim;
  logic [2:0]  tx_pat = 3'h7;
  logic [2:0]  txd;
  logic [2:0]  rxd;
  logic [6:0]  irq = 7'h0;
  logic [4:0]  lat;
  logic [5:0]  aux;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #20 clk_i = ~clk_i;

  sppr_far_model u_far (.run_i(run), .tx_pat_i(tx_pat), .pin_pat_i(pin_pat),
    .claim_i(claim), .txd_o(txd), .pin_o(pin_in));

  sppr_router u_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr),
    .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pin_claim_o(claim),
    .uart0_txd_i(txd[0]), .uart1_txd_i(txd[1]), .uart2_txd_i(txd[2]),
    .uart0_rxd_o(rxd[0]), .uart1_rxd_o(rxd[1]), .uart2_rxd_o(rxd[2]),
    .clocked_serial_out_first_i(v), .clocked_serial_clk_first_i(v),
    .clocked_serial_clk_oe_first_i(v), .clocked_serial_in_first_o(aux[0]),
    .clocked_serial_clk_first_o(aux[1]), .clocked_serial_out_second_i(v),
    .clocked_serial_clk_second_i(v), .clocked_serial_clk_oe_second_i(v),
    .clocked_serial_in_second_o(aux[2]), .clocked_serial_clk_second_o(aux[3]),
    .i2c_sda_low_i(v), .i2c_scl_low_i(v), .i2c_sda_o(aux[4]), .i2c_scl_o(aux[5]),
    .tx_irq_chan0_i(irq[6]), .rx_irq_chan0_i(irq[5]), .i2c_irq_i(irq[4]),
    .clocked_serial_irq_first_i(irq[3]), .clocked_serial_irq_second_i(irq[2]),
    .tx_irq_chan1_i(irq[1]), .rx_irq_chan1_i(irq[0]),
    .irq_latch_seven_o(lat[4]), .irq_latch_six_o(lat[3]),
    .irq_latch_fifteen_o(lat[2]), .irq_latch_twentythree_o(lat[1]),
    .irq_latch_twentytwo_o(lat[0]));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge clk_i);
    rd = 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask : reg_rd

  task automatic test_done();
    $display("Checks: %0d, mismatches: %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      error_cnt++;
      test_done();
    end
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    int         t;
    int         r;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    reg_rd(ADDR_SWAP, d);
    chk(16'(d), 16'h0);
    reg_rd(ADDR_SEL, d);
    chk(16'(d), 16'h0);
    foreach (rows[i])
    begin
      run = 1'b0;
      reg_wr(ADDR_SWAP, rows[i].swap | 8'hF8);
      reg_wr(ADDR_SEL, rows[i].sel);
      reg_rd(ADDR_SWAP, d);
      chk(16'(d), 16'(rows[i].swap));
      run = 1'b1;
      for (int k = 1; k >= 0; k--)
      begin
        v = k[0];
        tx_pat = {3{v}};
        irq = v ? rows[i].irq : 7'h0;
        pin_pat = 13'h0;
        for (int c = 0; c < 3; c++)
          if (rows[i].pins[19-8*c -: 4] != 4'hF)
            pin_pat[rows[i].pins[19-8*c -: 4]] = v;
        repeat (3) @(negedge clk_i);
        chk(16'(claim), 16'(rows[i].claim));
        chk(16'(lat), v ? 16'(rows[i].lat) : 16'h0);
        for (int c = 0; c < 3; c++)
        begin
          t = int'(rows[i].pins[23-8*c -: 4]);
          r = int'(rows[i].pins[19-8*c -: 4]);
          chk(16'(rxd[c]), 16'(v && r != 15));
          if (t != 15)
            chk(16'({pin_out[t], pin_oe[t]}), 16'({v, 1'b1}));
        end
      end
    end
    // Select keeps only its five defined bits
    reg_wr(ADDR_SEL, 8'hFF);
    reg_rd(ADDR_SEL, d);
    chk(16'(d), 16'h1F);
    // Reset in mid-run clears both registers
    reg_wr(ADDR_SWAP, 8'h07);
    @(negedge clk_i);
    srst_i = 1'b1;
    @(negedge clk_i);
    srst_i = 1'b0;
    reg_rd(ADDR_SWAP, d);
    chk(16'(d), 16'h0);
    reg_rd(ADDR_SEL, d);
    chk(16'(d), 16'h0);
    // Frozen clock enable and unmapped writes leave the swap untouched
    ce_i = 1'b0;
    reg_wr(ADDR_SWAP, 8'h05);
    ce_i = 1'b1;
    reg_wr(12'hF56, 8'hFF);
    reg_rd(ADDR_SWAP, d);
    chk(16'(d), 16'h0);
    reg_rd(12'hF56, d);
    chk(16'(d), 16'h0);
    // Clocked serial and I2C lines of selection 10 on both groups
    reg_wr(ADDR_SEL, 8'h0A);
    for (int k = 1; k >= 0; k--)
    begin
      v = k[0];
      pin_pat = {13{v}};
      repeat (3) @(negedge clk_i);
      chk(16'(aux), v ? 16'h3F : 16'h0);
      chk(16'({pin_out[PIN_20], pin_out[PIN_22], pin_out[PIN_90], pin_oe[PIN_23]}),
        v ? 16'hF : 16'h0);
    end
    test_done();
  end
endmodule : serial_port_pin_router_tb_top
